// [reset_mode_pkg.sv]
/*
 * shared constants of the reset, mode-latch and interrupt-pin block:
 * register offsets, field positions, reset values and the core state type.
 * assumes a byte-addressed avalon-mm slave with 32-bit data.
 */
`default_nettype none
package reset_mode_pkg;
	// ======================================================================
	// register offsets (byte addresses)
	localparam logic [4:0] OFS_MODE      = 5'h00;
	localparam logic [4:0] OFS_PLL       = 5'h04;
	localparam logic [4:0] OFS_IRQ_CFG   = 5'h08;
	localparam logic [4:0] OFS_IRQ_STAT  = 5'h0C;
	localparam logic [4:0] OFS_CORE_CTRL = 5'h10;
	localparam logic [4:0] OFS_STATUS    = 5'h14;

	// ======================================================================
	// field positions
	localparam int PLL_EN_BIT    = 0;
	localparam int PLL_DF_LSB    = 4;
	localparam int PLL_MF_LSB    = 8;
	localparam int CFG_EDGE_LSB  = 8;
	localparam int STAT_NMI_BIT  = 8;
	localparam int STS_HELD_BIT  = 2;
	localparam int STS_ALIGN_BIT = 3;

	// ======================================================================
	// reset values, limits and core commands
	localparam logic [3:0] MODE_RST      = 4'h0;
	localparam logic [3:0] DF_RST        = 4'h1;
	localparam logic [3:0] MF_RST        = 4'h1;
	localparam logic [3:0] DF_ALIGN      = 4'h1;
	localparam logic [3:0] MF_ALIGN_MAX  = 4'h4;
	localparam logic [3:0] MASK_RST      = 4'h0;
	localparam logic [3:0] EDGE_RST      = 4'h0;
	localparam logic [1:0] CMD_WAIT      = 2'h1;
	localparam logic [1:0] CMD_STOP      = 2'h2;

	// ======================================================================
	// processor states
	typedef enum logic [1:0] {
		ST_RUN  = 2'b00,
		ST_WAIT = 2'b01,
		ST_STOP = 2'b10,
		ST_HELD = 2'b11
	} core_state_type;
endpackage
`default_nettype wire

// [reset_mode_latch_irq_pins.sv]
/*
 * reset, mode-strap latch and interrupt-pin logic of the signal processor.
 * the board pin reset is synchronised and released on a rising edge of the
 * divided output clock; at that moment the four mode straps and the pll-init
 * strap are captured. afterwards the straps serve as interrupt requests.
 * assumes: ref_clk is the input clock at 100 MHz, reset_n a synchronous
 * block reset, all pins asynchronous to ref_clk, avalon-mm master on ref_clk.
 */
// How it works
// - board reset held low keeps core held and phase generator cleared
// - leaving the held state happens only on an output clock rising edge
// - release delay is fixed, so devices released together start in lockstep
// - four mode straps are captured into the operating mode register on release
// - pll-init strap level is captured into the pll enable bit on release
// - after release the pll-init pin is a falling-edge non-maskable request
// - straps a and b become active-low maskable requests, level or edge
// - a maskable request pending in stop state returns the core to run
// - a masked-in request in wait state leaves wait on a fixed clock edge
// - output clock follows core phase; aligned flag shows input alignment
// - with the pll off the output clock runs at half the input clock
// - straps c and d behave as requests exactly like a and b
`timescale 1ns/100ps
`default_nettype none
module reset_mode_latch_irq_pins (
	// clock and block reset
	input  wire  logic        ref_clk,
	input  wire  logic        reset_n,
	// board pins
	input  wire  logic        ext_reset_n,
	input  wire  logic        mode_sel_a,
	input  wire  logic        mode_sel_b,
	input  wire  logic        mode_sel_c,
	input  wire  logic        mode_sel_d,
	input  wire  logic        pll_init_pin,
	output logic              core_clock_out,
	// core-side status
	output logic              core_in_reset,
	output logic [1:0]        core_state,
	output logic [3:0]        operating_mode,
	output logic              pll_enable,
	output logic              clock_aligned,
	output logic              irq_request,
	output logic              nmi_request,
	// avalon-mm slave
	input  wire  logic [4:0]  address,
	input  wire  logic        read,
	input  wire  logic        write,
	input  wire  logic [31:0] writedata,
	output logic [31:0]       readdata,
	output logic              waitrequest
);
	// ======================================================================
	// declarations
	reset_mode_pkg::core_state_type state_r;
	logic [5:0]  pin_s1_r;                  // first synchroniser stage
	logic [5:0]  pin_s2_r;                  // second synchroniser stage
	logic [4:0]  samp_r;                    // sampled on output clock rise
	logic [4:0]  fall_r;                    // one-cycle falling-edge pulses
	logic [3:0]  half_cnt_r;
	logic        core_clock_out_r;
	logic        tick;
	logic        rise_tick;
	logic        rst_pin_n;
	logic [3:0]  operating_mode_r;
	logic        pll_enable_bit_r;
	logic [3:0]  pll_divide_factor_r;
	logic [3:0]  pll_multiply_factor_r;
	logic [3:0]  mask_r;
	logic [3:0]  edge_mode_r;
	logic [3:0]  pend_r;
	logic        nmi_pend_r;
	logic [3:0]  irq_active;
	logic [3:0]  irq_clr;
	logic        nmi_clr;
	logic        running;
	logic        ack_r;
	logic        wr_go;
	logic [31:0] readdata_r;

	// ======================================================================
	// helpers

	// half-period of the output clock in input cycles, minus one
	function automatic logic [3:0] half_limit(input logic en, input logic [3:0] df);
		if (!en || df == 4'h0) begin
			return 4'h0;
		end
		return df - 4'h1;
	endfunction

	// read-data mux
	function automatic logic [31:0] read_mux(input logic [4:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			reset_mode_pkg::OFS_MODE: begin
				v[3:0] = operating_mode_r;
			end
			reset_mode_pkg::OFS_PLL: begin
				v[reset_mode_pkg::PLL_EN_BIT] = pll_enable_bit_r;
				v[reset_mode_pkg::PLL_DF_LSB +: 4] = pll_divide_factor_r;
				v[reset_mode_pkg::PLL_MF_LSB +: 4] = pll_multiply_factor_r;
			end
			reset_mode_pkg::OFS_IRQ_CFG: begin
				v[3:0] = mask_r;
				v[reset_mode_pkg::CFG_EDGE_LSB +: 4] = edge_mode_r;
			end
			reset_mode_pkg::OFS_IRQ_STAT: begin
				v[3:0] = irq_active;
				v[reset_mode_pkg::STAT_NMI_BIT] = nmi_pend_r;
			end
			reset_mode_pkg::OFS_STATUS: begin
				v[1:0] = state_r;
				v[reset_mode_pkg::STS_HELD_BIT] = (state_r == reset_mode_pkg::ST_HELD);
				v[reset_mode_pkg::STS_ALIGN_BIT] = clock_aligned;
			end
			default: begin
				v = 32'h0000_0000;
			end
		endcase
		return v;
	endfunction

	// ======================================================================
	// pin synchronisers: {reset, pll-init, d, c, b, a}
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pin_s1_r <= 6'h00;
			pin_s2_r <= 6'h00;
		end else begin
			pin_s1_r <= {ext_reset_n, pll_init_pin, mode_sel_d, mode_sel_c, mode_sel_b, mode_sel_a};
			pin_s2_r <= pin_s1_r;
		end
	end

	assign rst_pin_n = pin_s2_r[5];

	// ======================================================================
	// phase generator and output clock
	assign tick      = (half_cnt_r >= half_limit(pll_enable_bit_r, pll_divide_factor_r));
	assign rise_tick = tick && !core_clock_out_r;

	always_ff @(posedge ref_clk) begin
		if (!reset_n || !rst_pin_n) begin
			half_cnt_r <= 4'h0;
			core_clock_out_r   <= 1'b0;
		end else if (tick) begin
			half_cnt_r <= 4'h0;
			core_clock_out_r   <= !core_clock_out_r;
		end else begin
			half_cnt_r <= half_cnt_r + 4'h1;
		end
	end

	assign core_clock_out = core_clock_out_r;
	assign clock_aligned  = !pll_enable_bit_r ||
		(pll_divide_factor_r == reset_mode_pkg::DF_ALIGN &&
		 pll_multiply_factor_r <= reset_mode_pkg::MF_ALIGN_MAX);

	// ======================================================================
	// pin sampling on output clock rise and falling-edge pulses
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			samp_r <= 5'h1F;
			fall_r <= 5'h00;
		end else if (rise_tick) begin
			samp_r <= pin_s2_r[4:0];
			fall_r <= samp_r & ~pin_s2_r[4:0];
		end else begin
			fall_r <= 5'h00;
		end
	end

	// ======================================================================
	// avalon slave: one wait cycle, then the answer
	assign waitrequest = (read || write) && !ack_r;
	assign wr_go       = write && ack_r;
	assign readdata    = readdata_r;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (read || write) && !ack_r;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			readdata_r <= 32'h0000_0000;
		end else if (read && !ack_r) begin
			readdata_r <= read_mux(address);
		end
	end

	// ======================================================================
	// straps captured at release, then software-writable
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			operating_mode_r <= reset_mode_pkg::MODE_RST;
			pll_enable_bit_r <= 1'b0;
		end else if (state_r == reset_mode_pkg::ST_HELD && rst_pin_n && rise_tick) begin
			operating_mode_r <= samp_r[3:0];
			pll_enable_bit_r <= samp_r[4];
		end else if (wr_go && address == reset_mode_pkg::OFS_MODE) begin
			operating_mode_r <= writedata[3:0];
		end else if (wr_go && address == reset_mode_pkg::OFS_PLL) begin
			pll_enable_bit_r <= writedata[reset_mode_pkg::PLL_EN_BIT];
		end
	end

	// pll factors and interrupt configuration
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pll_divide_factor_r   <= reset_mode_pkg::DF_RST;
			pll_multiply_factor_r <= reset_mode_pkg::MF_RST;
			mask_r                <= reset_mode_pkg::MASK_RST;
			edge_mode_r           <= reset_mode_pkg::EDGE_RST;
		end else if (wr_go && address == reset_mode_pkg::OFS_PLL) begin
			pll_divide_factor_r   <= writedata[reset_mode_pkg::PLL_DF_LSB +: 4];
			pll_multiply_factor_r <= writedata[reset_mode_pkg::PLL_MF_LSB +: 4];
		end else if (wr_go && address == reset_mode_pkg::OFS_IRQ_CFG) begin
			mask_r      <= writedata[3:0];
			edge_mode_r <= writedata[reset_mode_pkg::CFG_EDGE_LSB +: 4];
		end
	end

	// ======================================================================
	// interrupt requests; write one to clear, a new edge wins over the clear
	assign running = (state_r != reset_mode_pkg::ST_HELD);
	assign irq_clr = (wr_go && address == reset_mode_pkg::OFS_IRQ_STAT) ? writedata[3:0] : 4'h0;
	assign nmi_clr = wr_go && address == reset_mode_pkg::OFS_IRQ_STAT &&
		writedata[reset_mode_pkg::STAT_NMI_BIT];

	always_ff @(posedge ref_clk) begin
		if (!reset_n || !running) begin
			pend_r     <= 4'h0;
			nmi_pend_r <= 1'b0;
		end else begin
			pend_r     <= (pend_r & ~irq_clr) | (fall_r[3:0] & edge_mode_r);
			nmi_pend_r <= (nmi_pend_r && !nmi_clr) || fall_r[4];
		end
	end

	// level mode follows the sampled low level, edge mode the latch
	assign irq_active  = running ? ((edge_mode_r & pend_r) | (~edge_mode_r & ~samp_r[3:0])) : 4'h0;
	assign irq_request = |(irq_active & mask_r);
	assign nmi_request = nmi_pend_r;

	// ======================================================================
	// processor state: held, run, wait, stop
	always_ff @(posedge ref_clk) begin
		if (!reset_n || !rst_pin_n) begin
			state_r <= reset_mode_pkg::ST_HELD;
		end else begin
			unique case (state_r)
				reset_mode_pkg::ST_HELD: begin
					if (rise_tick) begin
						state_r <= reset_mode_pkg::ST_RUN;
					end
				end
				reset_mode_pkg::ST_RUN: begin
					if (wr_go && address == reset_mode_pkg::OFS_CORE_CTRL) begin
						if (writedata[1:0] == reset_mode_pkg::CMD_WAIT) begin
							state_r <= reset_mode_pkg::ST_WAIT;
						end else if (writedata[1:0] == reset_mode_pkg::CMD_STOP) begin
							state_r <= reset_mode_pkg::ST_STOP;
						end
					end
				end
				reset_mode_pkg::ST_WAIT: begin
					if (rise_tick && (irq_request || nmi_request)) begin
						state_r <= reset_mode_pkg::ST_RUN;
					end
				end
				reset_mode_pkg::ST_STOP: begin
					if (rise_tick && |irq_active) begin
						state_r <= reset_mode_pkg::ST_RUN;
					end
				end
			endcase
		end
	end

	assign core_in_reset  = (state_r == reset_mode_pkg::ST_HELD);
	assign core_state     = state_r;
	assign operating_mode = operating_mode_r;
	assign pll_enable     = pll_enable_bit_r;

	// ======================================================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	a_phase_held_clear: assert property (!rst_pin_n |=> !core_clock_out_r && half_cnt_r == 4'h0 && core_in_reset)
		else $error("phase generator not cleared under board reset");

	a_release_on_rise: assert property ($past(state_r) == reset_mode_pkg::ST_HELD &&
		state_r == reset_mode_pkg::ST_RUN |-> $past(rise_tick))
		else $error("reset left off an output clock rise");

	a_release_bounded: assert property ($rose(rst_pin_n) && core_in_reset |-> ##[1:40] !core_in_reset)
		else $error("release took too long");

	a_mode_capture: assert property (core_in_reset && rst_pin_n && rise_tick |=>
		operating_mode_r == $past(samp_r[3:0]) && !core_in_reset)
		else $error("mode straps not captured at release");

	a_pen_capture: assert property (core_in_reset && rst_pin_n && rise_tick |=>
		pll_enable_bit_r == $past(samp_r[4]))
		else $error("pll enable not captured at release");

	a_nmi_edge_latch: assert property (running && fall_r[4] ##1 running |-> nmi_request)
		else $error("nmi edge lost");

	a_irq_edge_latch: assert property (running && fall_r[0] && edge_mode_r[0] ##1 running |-> pend_r[0])
		else $error("edge request a lost");

	a_stop_exit: assert property (state_r == reset_mode_pkg::ST_STOP && rise_tick && |irq_active &&
		rst_pin_n |=> state_r == reset_mode_pkg::ST_RUN)
		else $error("stop not left on request");

	a_wait_exit: assert property (state_r == reset_mode_pkg::ST_WAIT && rise_tick && irq_request &&
		rst_pin_n |=> state_r == reset_mode_pkg::ST_RUN)
		else $error("wait not left on request");

	a_align_flag: assert property (!pll_enable_bit_r |-> clock_aligned)
		else $error("pll off yet not aligned");

	a_half_rate: assert property (!pll_enable_bit_r && rst_pin_n ##1 rst_pin_n |-> core_clock_out_r != $past(core_clock_out_r))
		else $error("output clock not half the input rate");

	a_level_track: assert property (running && !edge_mode_r[3] |-> irq_active[3] == !samp_r[3])
		else $error("level request d not tracking pin");

	a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest) // answer after one wait
		else $error("bus answer late");
endmodule
`default_nettype wire

// [board_pins_model.sv]
/*
 * board-side model: board reset, mode straps, then interrupt pins.
 * assumes commands change just after rising ref_clk edges.
 */
`timescale 1ns/100ps
`default_nettype none
module board_pins_model (
	// clock
	input  wire  logic       ref_clk,
	// bench commands
	input  wire  logic       hold_rst,
	input  wire  logic [4:0] strap,
	input  wire  logic [3:0] irq_n,
	input  wire  logic       nmi_n,
	// board pins
	output logic             ext_reset_n,
	output logic             mode_sel_a,
	output logic             mode_sel_b,
	output logic             mode_sel_c,
	output logic             mode_sel_d,
	output logic             pll_init_pin
);
	// ======================================================================
	// strap hold: straps outlive the capture point after release
	logic [3:0] hold_cnt_r;
	always_ff @(posedge ref_clk) begin
		if (hold_rst) begin
			hold_cnt_r <= 4'h0;
		end else if (hold_cnt_r != 4'hF) begin
			hold_cnt_r <= hold_cnt_r + 4'h1;
		end
	end
	// reset pin moves only on clock edges, so release is synchronous
	always_ff @(posedge ref_clk) begin
		ext_reset_n <= ~hold_rst;
	end
	// straps during reset, interrupt lines afterwards
	always_ff @(posedge ref_clk) begin
		if (hold_rst || hold_cnt_r != 4'hF) begin
			{pll_init_pin, mode_sel_d, mode_sel_c, mode_sel_b, mode_sel_a} <= strap;
		end else begin
			{pll_init_pin, mode_sel_d, mode_sel_c, mode_sel_b, mode_sel_a} <= {nmi_n, irq_n};
		end
	end
endmodule
`default_nettype wire

// [tb.sv]
/*
 * self-checking bench of the reset, strap-latch and interrupt-pin block.
 * assumes the board model drives the pins and the bench is avalon master.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
	// ======================================================================
	// signals
	logic        ref_clk, reset_n, hold_rst, nmi_n;
	logic [4:0]  strap;
	logic [3:0]  irq_n;
	logic        ext_reset_n, mode_sel_a, mode_sel_b, mode_sel_c, mode_sel_d, pll_init_pin;
	logic        core_clock_out, core_in_reset, pll_enable, clock_aligned, irq_request, nmi_request;
	logic [1:0]  core_state;
	logic [3:0]  operating_mode;
	logic [4:0]  address;
	logic        read, write, waitrequest;
	logic [31:0] writedata, readdata;
	int          err_total = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          d1, d2;

	board_pins_model i_board_pins_model (.ref_clk(ref_clk), .hold_rst(hold_rst), .strap(strap),
		.irq_n(irq_n), .nmi_n(nmi_n), .ext_reset_n(ext_reset_n), .mode_sel_a(mode_sel_a),
		.mode_sel_b(mode_sel_b), .mode_sel_c(mode_sel_c), .mode_sel_d(mode_sel_d),
		.pll_init_pin(pll_init_pin));
	reset_mode_latch_irq_pins i_reset_mode_latch_irq_pins (.ref_clk(ref_clk), .reset_n(reset_n),
		.ext_reset_n(ext_reset_n), .mode_sel_a(mode_sel_a), .mode_sel_b(mode_sel_b),
		.mode_sel_c(mode_sel_c), .mode_sel_d(mode_sel_d), .pll_init_pin(pll_init_pin),
		.core_clock_out(core_clock_out), .core_in_reset(core_in_reset), .core_state(core_state),
		.operating_mode(operating_mode), .pll_enable(pll_enable), .clock_aligned(clock_aligned),
		.irq_request(irq_request), .nmi_request(nmi_request), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));

	// ======================================================================
	// clock and hang guard
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			$display("BAD %0t timeout", $time);
			tally_and_finish();
		end
	end

	// ======================================================================
	// shared tasks
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// request held until the edge that samples waitrequest low
	task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		address <= a;
		read    <= 1'b1;
		do @(posedge ref_clk); while (waitrequest !== 1'b0);
		d = readdata;
		read <= 1'b0;
	endtask
	task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		address   <= a;
		writedata <= d;
		write     <= 1'b1;
		do @(posedge ref_clk); while (waitrequest !== 1'b0);
		write <= 1'b0;
	endtask

	// ======================================================================
	// scenarios
	task automatic t_reset(input logic [4:0] s, output int d);
		logic [31:0] v;
		@(posedge ref_clk);
		hold_rst <= 1'b1;
		strap    <= s;
		repeat (10) @(posedge ref_clk);
		chk(core_in_reset, 1'b1, "held flag");
		chk(core_state, reset_mode_pkg::ST_HELD, "held state");
		chk(core_clock_out, 1'b0, "clock cleared");
		hold_rst <= 1'b0;
		d = 0;
		while (core_in_reset !== 1'b0 && d < 40) begin
			@(posedge ref_clk);
			d++;
		end
		chk(d >= 3 && d <= 8, 1'b1, "release delay");
		chk(operating_mode, s[3:0], "mode latched");
		chk(pll_enable, s[4], "pll enable latched");
		bus_rd(reset_mode_pkg::OFS_MODE, v);
		chk(v, {28'h0, s[3:0]}, "mode reg");
		bus_rd(reset_mode_pkg::OFS_PLL, v);
		chk(v, {20'h0, reset_mode_pkg::MF_RST, reset_mode_pkg::DF_RST, 3'h0, s[4]}, "pll reg");
	endtask
	task automatic t_bus();
		logic [31:0] v;
		bus_wr(5'h18, 32'hFFFF_FFFF);
		bus_rd(5'h18, v);
		chk(v, 32'h0, "unmapped read");
		bus_wr(reset_mode_pkg::OFS_STATUS, 32'hFFFF_FFFF);
		bus_rd(reset_mode_pkg::OFS_STATUS, v);
		chk(v, 32'h0000_0008, "status read-only");
	endtask
	// alignment table, then output clock rate with the pll off
	task automatic t_clock();
		logic [31:0] pv [4] = '{32'h0000_0411, 32'h0000_0511, 32'h0000_0421, 32'h0000_0110};
		logic        av [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
		logic        p;
		for (int i = 0; i < 4; i++) begin
			bus_wr(reset_mode_pkg::OFS_PLL, pv[i]);
			@(posedge ref_clk);
			chk(clock_aligned, av[i], "aligned flag");
		end
		repeat (6) @(posedge ref_clk);
		p = core_clock_out;
		repeat (8) begin
			@(posedge ref_clk);
			chk(core_clock_out, !p, "half rate clock");
			p = core_clock_out;
		end
	endtask
	// masked pin: status shows it, request line stays low
	task automatic t_mask();
		logic [31:0] v;
		bus_wr(reset_mode_pkg::OFS_IRQ_CFG, 32'h0);
		irq_n <= 4'hE;
		repeat (10) @(posedge ref_clk);
		chk(irq_request, 1'b0, "masked pin");
		bus_rd(reset_mode_pkg::OFS_IRQ_STAT, v);
		chk(v[3:0], 4'h1, "level tracked");
		irq_n <= 4'hF;
	endtask
	task automatic irq_pin(input int i, input logic e);
		logic [31:0] v;
		int          k;
		bus_wr(reset_mode_pkg::OFS_IRQ_CFG, (32'(e) << (8 + i)) | (32'h1 << i));
		irq_n <= ~(4'h1 << i);
		for (k = 0; k < 30 && irq_request !== 1'b1; k++) @(posedge ref_clk);
		chk(irq_request, 1'b1, "pin request");
		bus_rd(reset_mode_pkg::OFS_IRQ_STAT, v);
		chk(v[3:0], 4'h1 << i, "pin status");
		irq_n <= 4'hF;
		repeat (10) @(posedge ref_clk);
		chk(irq_request, e, "edge sticks, level follows");
		bus_wr(reset_mode_pkg::OFS_IRQ_STAT, 32'h1 << i);
		repeat (3) @(posedge ref_clk);
		chk(irq_request, 1'b0, "cleared");
	endtask
	task automatic t_nmi();
		logic [31:0] v;
		int          k;
		chk(nmi_request, 1'b0, "no nmi yet");
		nmi_n <= 1'b0;
		for (k = 0; k < 30 && nmi_request !== 1'b1; k++) @(posedge ref_clk);
		nmi_n <= 1'b1;
		repeat (10) @(posedge ref_clk);
		chk(nmi_request, 1'b1, "nmi latched on fall");
		bus_rd(reset_mode_pkg::OFS_IRQ_STAT, v);
		chk(v[reset_mode_pkg::STAT_NMI_BIT], 1'b1, "nmi status");
		bus_wr(reset_mode_pkg::OFS_IRQ_STAT, 32'h0000_0100);
		repeat (3) @(posedge ref_clk);
		chk(nmi_request, 1'b0, "nmi cleared");
	endtask
	// stop exits on a masked-out pin, wait on a masked-in pin
	task automatic t_sleep(input logic [1:0] cmd, input logic [31:0] cfg);
		int k;
		bus_wr(reset_mode_pkg::OFS_IRQ_CFG, cfg);
		bus_wr(reset_mode_pkg::OFS_CORE_CTRL, {30'h0, cmd});
		repeat (4) @(posedge ref_clk);
		chk(core_state, cmd, "sleep entered");
		irq_n <= 4'hD;
		for (k = 0; k < 30 && core_state !== reset_mode_pkg::ST_RUN; k++) @(posedge ref_clk);
		chk(core_state, reset_mode_pkg::ST_RUN, "woken by pin");
		irq_n <= 4'hF;
		repeat (10) @(posedge ref_clk);
	endtask

	// ======================================================================
	// main sequence
	initial begin
		reset_n   = 1'b0;
		hold_rst  = 1'b1;
		strap     = 5'h00;
		irq_n     = 4'hF;
		nmi_n     = 1'b1;
		address   = 5'h00;
		read      = 1'b0;
		write     = 1'b0;
		writedata = 32'h0;
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_reset(5'h0A, d1);
		t_reset(5'h15, d2);
		chk(d1, d2, "repeatable start");
		repeat (20) @(posedge ref_clk);
		t_bus();
		t_clock();
		t_mask();
		for (int i = 0; i < 4; i++) irq_pin(i, i % 2 == 0);
		t_nmi();
		t_sleep(reset_mode_pkg::CMD_STOP, 32'h0);
		t_sleep(reset_mode_pkg::CMD_WAIT, 32'h2);
		tally_and_finish();
	end
endmodule
`default_nettype wire
